// *** inc/bsx_pkg.sv ***
package bsx_pkg;

    localparam int INSTR_W = 16;
    localparam int DATA_W  = 8;

    // sequencer states, gray along exec -> skip -> skip2
    typedef enum logic [1:0] {
        ST_EXEC  = 2'b00,
        ST_SKIP  = 2'b01,
        ST_SKIP2 = 2'b11,
        ST_HOLD  = 2'b10
    } bsx_state_t;

    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_CMP_IMM  = 4'h1,
        OP_SKIP_REG = 4'h2,
        OP_SKIP_IO  = 4'h3,
        OP_BRANCH   = 4'h4,
        OP_IO_BIT   = 4'h5,
        OP_SHL      = 4'h6,
        OP_ROTL     = 4'h7,
        OP_SHR      = 4'h8,
        OP_ROTR     = 4'h9,
        OP_SHRA     = 4'hA
    } bsx_op_t;

    // status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    // instruction fields
    localparam int POL_BIT    = 9;
    localparam int BR_POL_BIT = 10;
    localparam int BR_K_W     = 7;

    // opcode mask and match pairs
    localparam logic [15:0] MASK_CMP_IMM  = 16'hF000;
    localparam logic [15:0] MATCH_CMP_IMM = 16'h3000;
    localparam logic [15:0] MASK_SKREG    = 16'hFC08;
    localparam logic [15:0] MATCH_SKREG   = 16'hFC00;
    localparam logic [15:0] MASK_IO       = 16'hFD00;
    localparam logic [15:0] MATCH_SKIO    = 16'h9900;
    localparam logic [15:0] MATCH_IOBIT   = 16'h9800;
    localparam logic [15:0] MASK_BR       = 16'hF800;
    localparam logic [15:0] MATCH_BR      = 16'hF000;
    localparam logic [15:0] MASK_SHR      = 16'hFE0F;
    localparam logic [15:0] MATCH_SHR     = 16'h9406;
    localparam logic [15:0] MATCH_ROTR    = 16'h9407;
    localparam logic [15:0] MATCH_SHRA    = 16'h9405;
    localparam logic [15:0] MASK_SHL      = 16'hFC00;
    localparam logic [15:0] MATCH_SHL     = 16'h0C00;
    localparam logic [15:0] MATCH_ROTL    = 16'h1C00;
    localparam logic [15:0] MASK_LDST     = 16'hFC0F;
    localparam logic [15:0] MATCH_LDST    = 16'h9000;
    localparam logic [15:0] MASK_JMPC     = 16'hFE0C;
    localparam logic [15:0] MATCH_JMPC    = 16'h940C;

    // register port map
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_PC_LO  = 2'h2;
    localparam logic [1:0] REG_PC_HI  = 2'h3;
    localparam int         CTRL_RUN    = 0;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

endpackage

// *** core/bsx_alu.sv ***
module bsx_alu
    import bsx_pkg::*;
(
    // operation and operands
    input  wire bsx_op_t     op_in,
    input  wire logic [7:0]  opa_in,
    input  wire logic [7:0]  imm_in,
    input  wire logic [7:0]  flags_in,
    // results
    output logic      [7:0]  res_out,
    output logic      [7:0]  flags_out
);

    logic [7:0] r;
    logic       c;

    always_comb begin
        r         = opa_in;
        c         = flags_in[FLAG_C];
        flags_out = flags_in;
        case (op_in)
            OP_CMP_IMM: begin
                r = opa_in - imm_in;
                flags_out[FLAG_H] = (~opa_in[3] & imm_in[3]) |
                    (imm_in[3] & r[3]) | (r[3] & ~opa_in[3]);
                flags_out[FLAG_V] = (opa_in[7] & ~imm_in[7] & ~r[7]) |
                    (~opa_in[7] & imm_in[7] & r[7]);
                c = (~opa_in[7] & imm_in[7]) | (imm_in[7] & r[7]) |
                    (r[7] & ~opa_in[7]);
            end
            OP_SHL: begin
                r = {opa_in[6:0], 1'b0};
                c = opa_in[7];
            end
            OP_ROTL: begin
                r = {opa_in[6:0], flags_in[FLAG_C]};
                c = opa_in[7];
            end
            OP_SHR: begin
                r = {1'b0, opa_in[7:1]};
                c = opa_in[0];
            end
            OP_ROTR: begin
                r = {flags_in[FLAG_C], opa_in[7:1]};
                c = opa_in[0];
            end
            OP_SHRA: begin
                r = {opa_in[7], opa_in[7:1]};
                c = opa_in[0];
            end
            default: begin
                r = opa_in;
            end
        endcase
        res_out = r;
        if (op_in != OP_NONE && op_in != OP_SKIP_REG &&
            op_in != OP_SKIP_IO && op_in != OP_BRANCH &&
            op_in != OP_IO_BIT) begin
            flags_out[FLAG_C] = c;
            flags_out[FLAG_Z] = (r == 8'h00);
            flags_out[FLAG_N] = r[7];
            if (op_in != OP_CMP_IMM) begin
                flags_out[FLAG_V] = r[7] ^ c;
            end
            // keep the sign flag coherent for the signed branches
            flags_out[FLAG_S] = r[7] ^ flags_out[FLAG_V];
        end
    end

endmodule

// *** core/bsx_cond.sv ***
module bsx_cond
    import bsx_pkg::*;
(
    // decoded instruction
    input  wire bsx_op_t     op_in,
    input  wire logic [15:0] instr_in,
    // tested sources
    input  wire logic [7:0]  flags_in,
    input  wire logic [7:0]  gpr_in,
    input  wire logic [7:0]  io_in,
    // condition met
    output logic             take_out
);

    logic [2:0] sel;

    always_comb begin
        sel = instr_in[2:0];
        case (op_in)
            OP_SKIP_REG: take_out = (gpr_in[sel] == instr_in[POL_BIT]);
            OP_SKIP_IO:  take_out = (io_in[sel] == instr_in[POL_BIT]);
            // named forms are this test with a fixed flag
            // flags H, T, V and I are tested the same way
            OP_BRANCH:
                take_out = (flags_in[sel] == ~instr_in[BR_POL_BIT]);
            default:     take_out = 1'b0;
        endcase
    end

    // S bit holds N xor V, so the signed forms test it directly
    // interrupt enable sits at bit 7 of the flags

endmodule

// *** core/bsx_core.sv ***
// The placing of the registers and the address-and-strobe port were left to the implementer.
module bsx_core
    import bsx_pkg::*;
#(
    parameter int PC_W = 13
)
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    // program memory, combinational read
    output logic [PC_W-1:0]        prog_addr_out,
    input  wire logic [15:0]       prog_data_in,
    // working register file
    output logic [4:0]             gpr_raddr_out,
    input  wire logic [7:0]        gpr_rdata_in,
    output logic                   gpr_we_out,
    output logic [4:0]             gpr_waddr_out,
    output logic [7:0]             gpr_wdata_out,
    // low I/O space
    output logic [4:0]             io_raddr_out,
    input  wire logic [7:0]        io_rdata_in,
    output logic                   io_we_out,
    output logic [4:0]             io_waddr_out,
    output logic [7:0]             io_wdata_out,
    // register port
    input  wire logic [1:0]        reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [7:0]             reg_rdata_out,
    // status
    output logic [7:0]             flags_out
);

    if (PC_W < 9 || PC_W > 16) begin : g_pc_w_check
        $error("PC_W must lie in 9..16");
    end

    function automatic bsx_op_t decode_op(input logic [15:0] w);
        logic same;
        same = (w[9] == w[8]) && (w[3:0] == w[7:4]);
        if ((w & MASK_CMP_IMM) == MATCH_CMP_IMM) begin
            decode_op = OP_CMP_IMM;
        end else if ((w & MASK_SKREG) == MATCH_SKREG) begin
            decode_op = OP_SKIP_REG;
        end else if ((w & MASK_IO) == MATCH_SKIO) begin
            decode_op = OP_SKIP_IO;
        end else if ((w & MASK_IO) == MATCH_IOBIT) begin
            decode_op = OP_IO_BIT;
        end else if ((w & MASK_BR) == MATCH_BR) begin
            decode_op = OP_BRANCH;
        end else if ((w & MASK_SHR) == MATCH_SHR) begin
            decode_op = OP_SHR;
        end else if ((w & MASK_SHR) == MATCH_ROTR) begin
            decode_op = OP_ROTR;
        end else if ((w & MASK_SHR) == MATCH_SHRA) begin
            decode_op = OP_SHRA;
        end else if ((w & MASK_SHL) == MATCH_SHL && same) begin
            decode_op = OP_SHL;
        end else if ((w & MASK_SHL) == MATCH_ROTL && same) begin
            decode_op = OP_ROTL;
        end else begin
            decode_op = OP_NONE;
        end
    endfunction

    function automatic logic is_two_word(input logic [15:0] w);
        is_two_word = ((w & MASK_LDST) == MATCH_LDST) ||
                      ((w & MASK_JMPC) == MATCH_JMPC);
    endfunction

    bsx_state_t       state_reg, state_next;
    logic [PC_W-1:0]  pc_reg, pc_next;
    logic [7:0]       flags_reg, flags_next;
    logic [7:0]       ctrl_reg, ctrl_next;
    logic [7:0]       rdata_reg, rdata_next;
    logic             gpr_we_reg, gpr_we_next;
    logic [4:0]       gpr_waddr_reg, gpr_waddr_next;
    logic [7:0]       gpr_wdata_reg, gpr_wdata_next;
    logic             io_we_reg, io_we_next;
    logic [4:0]       io_waddr_reg, io_waddr_next;
    logic [7:0]       io_wdata_reg, io_wdata_next;

    logic             exec_go;
    bsx_op_t          op;
    logic [7:0]       gpr_val;
    logic [7:0]       alu_res;
    logic [7:0]       alu_flags;
    logic             take;
    logic [PC_W-1:0]  k_ext;
    logic [7:0]       bit_mask;

    assign exec_go = (state_reg == ST_EXEC) && ctrl_reg[CTRL_RUN];
    assign op      = exec_go ? decode_op(prog_data_in) : OP_NONE;

    // compare immediate reaches only the upper sixteen registers
    assign gpr_raddr_out = (op == OP_CMP_IMM) ? {1'b1, prog_data_in[7:4]}
                                              : prog_data_in[8:4];
    // forward a write still in flight to the next reader
    assign gpr_val = (gpr_we_reg && gpr_waddr_reg == gpr_raddr_out)
                     ? gpr_wdata_reg : gpr_rdata_in;
    assign io_raddr_out = prog_data_in[7:3];
    assign k_ext = PC_W'({{(16 - BR_K_W){prog_data_in[9]}},
                          prog_data_in[9:3]});
    assign bit_mask = 8'h01 << prog_data_in[2:0];

    bsx_alu u_alu (
        .op_in     (op),
        .opa_in    (gpr_val),
        .imm_in    ({prog_data_in[11:8], prog_data_in[3:0]}),
        .flags_in  (flags_reg),
        .res_out   (alu_res),
        .flags_out (alu_flags)
    );

    bsx_cond u_cond (
        .op_in    (op),
        .instr_in (prog_data_in),
        .flags_in (flags_reg),
        .gpr_in   (gpr_val),
        .io_in    (io_rdata_in),
        .take_out (take)
    );

    // sequencer and execute
    always_comb begin
        state_next     = state_reg;
        pc_next        = pc_reg;
        flags_next     = flags_reg;
        gpr_we_next    = 1'b0;
        gpr_waddr_next = gpr_waddr_reg;
        gpr_wdata_next = gpr_wdata_reg;
        io_we_next     = 1'b0;
        io_waddr_next  = io_waddr_reg;
        io_wdata_next  = io_wdata_reg;
        // software write first, so execution results take precedence
        if (reg_wr_in && reg_addr_in == REG_STATUS) begin
            flags_next = reg_wdata_in;
        end
        case (state_reg)
            ST_EXEC: begin
                if (ctrl_reg[CTRL_RUN]) begin
                    pc_next = pc_reg + PC_W'(1);
                    case (op)
                        OP_CMP_IMM: begin
                            flags_next = alu_flags;
                        end
                        OP_SKIP_REG, OP_SKIP_IO: begin
                            if (take) begin
                                state_next = ST_SKIP;
                            end
                        end
                        OP_BRANCH: begin
                            if (take) begin
                                pc_next    = pc_reg + PC_W'(1) + k_ext;
                                state_next = ST_HOLD;
                            end
                        end
                        OP_IO_BIT: begin
                            io_we_next    = 1'b1;
                            io_waddr_next = prog_data_in[7:3];
                            io_wdata_next = prog_data_in[POL_BIT]
                                ? (io_rdata_in | bit_mask)
                                : (io_rdata_in & ~bit_mask);
                            state_next    = ST_HOLD;
                        end
                        OP_SHL, OP_ROTL, OP_SHR, OP_ROTR, OP_SHRA: begin
                            flags_next     = alu_flags;
                            gpr_we_next    = 1'b1;
                            gpr_waddr_next = prog_data_in[8:4];
                            gpr_wdata_next = alu_res;
                        end
                        default: begin
                            pc_next = pc_reg + PC_W'(1);
                        end
                    endcase
                end
            end
            ST_SKIP: begin
                pc_next = pc_reg + PC_W'(1);
                if (is_two_word(prog_data_in)) begin
                    state_next = ST_SKIP2;
                end else begin
                    state_next = ST_EXEC;
                end
            end
            ST_SKIP2: begin
                pc_next    = pc_reg + PC_W'(1);
                state_next = ST_EXEC;
            end
            default: begin
                state_next = ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg     <= ST_EXEC;
            pc_reg        <= '0;
            flags_reg     <= FLAGS_RESET;
            gpr_we_reg    <= 1'b0;
            gpr_waddr_reg <= '0;
            gpr_wdata_reg <= '0;
            io_we_reg     <= 1'b0;
            io_waddr_reg  <= '0;
            io_wdata_reg  <= '0;
        end else begin
            state_reg     <= state_next;
            pc_reg        <= pc_next;
            flags_reg     <= flags_next;
            gpr_we_reg    <= gpr_we_next;
            gpr_waddr_reg <= gpr_waddr_next;
            gpr_wdata_reg <= gpr_wdata_next;
            io_we_reg     <= io_we_next;
            io_waddr_reg  <= io_waddr_next;
            io_wdata_reg  <= io_wdata_next;
        end
    end

    // register port
    always_comb begin
        ctrl_next  = ctrl_reg;
        rdata_next = 8'h00;
        if (reg_wr_in && reg_addr_in == REG_CTRL) begin
            ctrl_next = reg_wdata_in;
        end
        if (reg_rd_in) begin
            if (reg_addr_in == REG_CTRL) begin
                rdata_next = ctrl_reg;
            end else if (reg_addr_in == REG_STATUS) begin
                rdata_next = flags_reg;
            end else if (reg_addr_in == REG_PC_LO) begin
                rdata_next = pc_reg[7:0];
            end else begin
                rdata_next = 8'(pc_reg >> 8);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_reg  <= CTRL_RESET;
            rdata_reg <= 8'h00;
        end else begin
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    assign prog_addr_out = pc_reg;
    assign gpr_we_out    = gpr_we_reg;
    assign gpr_waddr_out = gpr_waddr_reg;
    assign gpr_wdata_out = gpr_wdata_reg;
    assign io_we_out     = io_we_reg;
    assign io_waddr_out  = io_waddr_reg;
    assign io_wdata_out  = io_wdata_reg;
    assign reg_rdata_out = rdata_reg;
    assign flags_out     = flags_reg;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_skip_taken;
        (op == OP_SKIP_REG || op == OP_SKIP_IO) && take;
    endsequence

    sequence s_skip_one_word;
        state_reg == ST_SKIP && !is_two_word(prog_data_in);
    endsequence

    AST_CMP_NO_WRITE: assert property (
        op == OP_CMP_IMM && !gpr_we_reg |=> !gpr_we_out)
        else $error("compare wrote a register");

    AST_CMP_ZERO: assert property (
        op == OP_CMP_IMM && !(reg_wr_in && reg_addr_in == REG_STATUS) |=>
        flags_out[FLAG_Z] == ($past(gpr_val) ==
            $past({prog_data_in[11:8], prog_data_in[3:0]})))
        else $error("compare zero flag wrong");

    AST_SIGN_FLAG: assert property (
        op == OP_CMP_IMM || op == OP_SHL || op == OP_ROTL ||
        op == OP_SHR || op == OP_ROTR || op == OP_SHRA |=>
        flags_out[FLAG_S] == (flags_out[FLAG_N] ^ flags_out[FLAG_V]))
        else $error("sign flag not negative xor overflow");

    AST_SKIP_ONE: assert property (
        s_skip_taken ##1 s_skip_one_word |=>
        state_reg == ST_EXEC && pc_reg == $past(pc_reg, 2) + PC_W'(2))
        else $error("one-word skip not two cycles");

    AST_SKIP_NOT: assert property (
        (op == OP_SKIP_REG || op == OP_SKIP_IO) && !take &&
        !(reg_wr_in && reg_addr_in == REG_STATUS) |=>
        state_reg == ST_EXEC && flags_out == $past(flags_out))
        else $error("untaken skip stalled or changed flags");

    AST_BR_TARGET: assert property (
        op == OP_BRANCH && take |=>
        pc_reg == $past(pc_reg) + PC_W'(1) + $past(k_ext)
        ##1 state_reg == ST_EXEC)
        else $error("branch target or timing wrong");

    AST_BR_NOT: assert property (
        op == OP_BRANCH && !take |=>
        state_reg == ST_EXEC && pc_reg == $past(pc_reg) + PC_W'(1))
        else $error("untaken branch not one cycle");

    AST_IO_BIT: assert property (
        op == OP_IO_BIT |=> io_we_out && state_reg == ST_HOLD &&
        io_wdata_out[$past(prog_data_in[2:0])] ==
            $past(prog_data_in[POL_BIT])
        ##1 !io_we_out && state_reg == ST_EXEC)
        else $error("I/O bit write wrong");

    AST_SHL: assert property (
        op == OP_SHL |=> gpr_we_out &&
        gpr_wdata_out == {$past(gpr_val[6:0]), 1'b0} &&
        flags_out[FLAG_C] == $past(gpr_val[7]))
        else $error("left shift wrong");

    AST_SHR_V: assert property (
        op == OP_SHR || op == OP_SHRA || op == OP_ROTR |=>
        flags_out[FLAG_V] == (flags_out[FLAG_N] ^ flags_out[FLAG_C]) &&
        flags_out[FLAG_C] == $past(gpr_val[0]))
        else $error("right shift flags wrong");

    AST_SHRA: assert property (
        op == OP_SHRA |=> gpr_we_out &&
        gpr_wdata_out == {$past(gpr_val[7]), $past(gpr_val[7:1])})
        else $error("arithmetic shift lost sign");

endmodule

// *** bench/bsx_core_tb_top.sv ***
module bsx_core_tb_top
    import bsx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rstn;
    logic [12:0] prog_addr;
    logic [15:0] prog[0:7];
    logic [7:0]  gpr[0:31];
    logic [7:0]  io[0:31];
    logic [4:0]  gpr_raddr, gpr_waddr, io_raddr, io_waddr;
    logic        gpr_we, io_we, reg_wr, reg_rd;
    logic [7:0]  gpr_wdata, io_wdata, reg_wdata, reg_rdata, flags;
    logic [1:0]  reg_addr;
    logic [7:0]  d;
    int          err_count, n_checks, gpr_writes, io_writes;

    bsx_core dut (
        .clk_in        (clk),
        .rstn_in       (rstn),
        .prog_addr_out (prog_addr),
        .prog_data_in  (prog[prog_addr[2:0]]),
        .gpr_raddr_out (gpr_raddr),
        .gpr_rdata_in  (gpr[gpr_raddr]),
        .gpr_we_out    (gpr_we),
        .gpr_waddr_out (gpr_waddr),
        .gpr_wdata_out (gpr_wdata),
        .io_raddr_out  (io_raddr),
        .io_rdata_in   (io[io_raddr]),
        .io_we_out     (io_we),
        .io_waddr_out  (io_waddr),
        .io_wdata_out  (io_wdata),
        .reg_addr_in   (reg_addr),
        .reg_wdata_in  (reg_wdata),
        .reg_wr_in     (reg_wr),
        .reg_rd_in     (reg_rd),
        .reg_rdata_out (reg_rdata),
        .flags_out     (flags)
    );

    always #2 clk = ~clk;

    // register file and low I/O space seen by the core
    always @(posedge clk) begin
        if (gpr_we === 1'b1) begin
            gpr[gpr_waddr] <= gpr_wdata;
            gpr_writes++;
        end
        if (io_we === 1'b1) begin
            io[io_waddr] <= io_wdata;
            io_writes++;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // self loop on a flag whose value is known
    function automatic logic [15:0] halt(input int s, input logic v);
        return 16'hF3F8 | (v ? 16'h0000 : 16'h0400) | 16'(s);
    endfunction

    task automatic load(input logic [15:0] w0, w1, w2, w3);
        foreach (prog[i]) prog[i] = halt(4, 1'b0);
        prog[0] = w0;
        prog[1] = w1;
        prog[2] = w2;
        prog[3] = w3;
    endtask

    // restart from address zero, run long enough to reach the loop
    task automatic run(input logic [7:0] st);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        gpr_writes = 0;
        io_writes = 0;
        reg_write(REG_STATUS, st);
        reg_write(REG_CTRL, 8'h01);
        repeat (40) @(posedge clk);
        reg_write(REG_CTRL, 8'h00);
        reg_read(REG_PC_LO, d);
    endtask

    task automatic t_regs();
        reg_read(REG_CTRL, d);
        chk(d, 8'h00);
        reg_read(REG_STATUS, d);
        chk(d, 8'h00);
        reg_write(REG_PC_HI, 8'h55);
        reg_read(REG_PC_HI, d);
        chk(d, 8'h00);
        reg_write(REG_STATUS, 8'hA5);
        reg_read(REG_STATUS, d);
        chk(d, 8'hA5);
    endtask

    task automatic t_cpi();
        gpr[16] = 8'h10;
        // signed less-than on the fresh flags jumps to the loop at 3
        load(16'h3200, 16'hF00C, halt(6, 1'b1), halt(6, 1'b1));
        run(8'h40);
        chk(d, 8'h03);
        chk(flags, 8'h55);
        chk(gpr[16], 8'h10);
        chk(16'(gpr_writes), 16'h0000);
    endtask

    task automatic t_shift();
        logic [15:0] op[5] = '{16'h0F44, 16'h1F44, 16'h9546, 16'h9545,
                               16'h9547};
        logic        cin[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic [7:0]  res[5] = '{8'h02, 8'h03, 8'h40, 8'hC0, 8'hC0};
        logic [7:0]  flg[5] = '{8'h39, 8'h39, 8'h39, 8'h35, 8'h35};
        for (int i = 0; i < 5; i++) begin
            gpr[20] = 8'h81;
            load(op[i], halt(5, 1'b1), 16'h0000, 16'h0000);
            run({8'h20 | 8'(cin[i])});
            chk(gpr[20], res[i]);
            chk(flags, flg[i]);
            chk(16'(gpr_writes), 16'h0001);
        end
    endtask

    task automatic t_branch();
        logic [7:0] st;
        for (int s = 0; s < 8; s++) begin
            for (int v = 0; v < 2; v++) begin
                for (int p = 0; p < 2; p++) begin
                    st = 8'(v << s);
                    load(16'hF010 | 16'(p << 10) | 16'(s), halt(s, v[0]),
                         halt(s, v[0]), halt(s, v[0]));
                    run(st);
                    chk(d, (v != p) ? 8'h03 : 8'h01);
                    chk(flags, st);
                    chk(flags, st);
                end
            end
        end
    endtask

    task automatic t_skip();
        logic [15:0] w;
        for (int f = 0; f < 2; f++) begin
            for (int p = 0; p < 2; p++) begin
                for (int v = 0; v < 2; v++) begin
                    gpr[5] = 8'(v << 3);
                    io[4] = 8'(v << 3);
                    io[6] = 8'h00;
                    w = f ? 16'h9923 : 16'hFC53;
                    load(w | 16'(p << 9), 16'h9A32, halt(4, 1'b0), 16'h0000);
                    run(8'h00);
                    chk(d, 8'h02);
                    chk(io[6], (v == p) ? 8'h00 : 8'h04);
                    chk(flags, 8'h00);
                end
            end
        end
        gpr[5] = 8'h08;
        io[6] = 8'h00;
        load(16'hFE53, 16'h940C, 16'h9A32, halt(4, 1'b0));
        run(8'h00);
        chk(d, 8'h03);
        chk(io[6], 8'h00);
    endtask

    task automatic t_iobit();
        for (int p = 0; p < 2; p++) begin
            io[6] = p ? 8'h00 : 8'hFF;
            load(16'h9832 | 16'(p << 9), halt(4, 1'b0), 16'h0000, 16'h0000);
            run(8'hAB);
            chk(io[6], p ? 8'h04 : 8'hFB);
            chk(16'(io_writes), 16'h0001);
            chk(flags, 8'hAB);
            chk(d, 8'h01);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        n_checks = 0;
        foreach (gpr[i]) gpr[i] = 8'h00;
        foreach (io[i]) io[i] = 8'h00;
        load(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_cpi();
        t_shift();
        t_branch();
        t_skip();
        t_iobit();
        tally_and_finish();
    end
endmodule
